// file: design/bcr_bridge_ctrl.sv
// bridge control register and express capability header of one switch port
// assumes an APB master on the same clock; window matching of I/O base and
// limit is done outside and arrives as a flag with each primary request
//
// Functional notes
// - poison response bit 0 ignores secondary poisoned packets, 1 reports them.
// - error forward bit gates ERR_COR/NONFATAL/FATAL from secondary to primary.
// - errors reach primary only if command or device control reporting enabled.
// - ISA bit clear forwards downstream every I/O address inside the window.
// - ISA bit set sends upstream window addresses below 64 KB, upper 768 bytes.
// - VGA bit passes VGA addresses primary to secondary when 1, blocks when 0.
// - VGA width bit matters only while the VGA forward bit is set.
// - width 0 decodes ten I/O address bits with aliases, 1 decodes sixteen.
// - secondary reset bit resets upstream secondary bus or the downstream link.
// - capability identifier is read-only and returns 0x10.
// - next pointer resets to 0xC0 and is writable only when unlocked.
// - capability version reports structure version, defaulting 0x1 in 1.1 mode.
// - port type reads 0x5 upstream and 0x6 downstream, read-only.
// - MSI vector number field always reads zero.
// - traffic class routing support defaults 1, or 0 in 1.1 mode.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module bcr_bridge_ctrl
    import bcr_pkg::*;
(
    input  wire logic        CLOCK,                // core clock
    input  wire logic        SYS_RST,              // sync reset, high
    input  wire logic        PSEL,                 // apb select
    input  wire logic        PENABLE,              // apb access phase
    input  wire logic        PWRITE,               // apb write
    input  wire logic [11:0] PADDR,                // apb byte address
    input  wire logic [31:0] PWDATA,               // apb write data
    input  wire logic [3:0]  PSTRB,                // apb byte strobes
    output logic      [31:0] PRDATA,               // apb read data
    output logic             PREADY,               // apb ready
    output logic             PSLVERR,              // apb error, unmapped
    input  wire logic        UPSTREAM_PORT,        // strap: port is upstream
    input  wire logic        PCIE11_MODE,          // strap: 1.1 mode
    input  wire logic        CMD_ERR_REPORT_EN,    // command reg reporting
    input  wire logic        DEVCTL_ERR_REPORT_EN, // device control reporting
    input  wire logic        SEC_POISON_SEEN,      // poisoned packet pulse
    output logic             POISON_REPORT,        // poison report pulse
    input  wire logic        SEC_ERR_VALID,        // secondary error message
    input  wire logic [1:0]  SEC_ERR_TYPE,         // 0 cor 1 nonfatal 2 fatal
    output logic             PRI_ERR_VALID,        // forwarded error pulse
    output logic      [1:0]  PRI_ERR_TYPE,         // forwarded error type
    input  bcr_req_t         PRI_REQ,              // primary request to decode
    output logic             DEC_VALID,            // decode result valid
    output logic             DEC_TO_SECONDARY,     // 1 forward down, 0 not
    output logic             SEC_RESET_UPSTREAM,   // upstream secondary reset
    output logic             SEC_RESET_LINK        // downstream link reset
);

    // ========================================================
    // state
    bcr_bridge_control_t  bridge_control_ff;
    bcr_bridge_control_t  nxt_bridge_control;
    bcr_cap_t    cap_ff;
    bcr_cap_t    nxt_cap;
    logic        unlock_ff;
    logic        port_up_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic        poison_ff;
    logic        err_valid_ff;
    logic [1:0]  err_type_ff;
    logic        dec_valid_ff;
    logic        dec_down_ff;
    logic        rst_up_ff;
    logic        rst_link_ff;

    logic        addr_hit;
    logic        wr_en;
    logic [31:0] rd_data;
    logic [15:0] bc_wmask;
    logic [31:0] cap_wmask;
    logic        isa_upstream;
    logic        vga_io_match;
    logic        vga_hit;

    // ========================================================
    // apb slave: one wait state, answer on the second access cycle
    always_comb begin
        addr_hit = (PADDR == ADDR_BRIDGE_CTRL) || (PADDR == ADDR_EXP_CAP)
                   || (PADDR == ADDR_CFG_LOCK);
    end

    // write commits only at the edge where the master sees pready high
    assign wr_en = PSEL && PENABLE && pready_ff && PWRITE && addr_hit;

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (PADDR)
            ADDR_BRIDGE_CTRL: begin
                rd_data = {16'h0000, bridge_control_ff & BC_RW_MASK};
            end
            ADDR_EXP_CAP: begin
                rd_data = cap_ff;
            end
            ADDR_CFG_LOCK: begin
                rd_data = {31'h0000_0000, unlock_ff};
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (PSEL && PENABLE && !pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= !addr_hit;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // read data stands until the next answer, so a slow sampler still sees it
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            prdata_ff <= 32'h0000_0000;
        end else if (PSEL && PENABLE && !pready_ff) begin
            prdata_ff <= PWRITE ? 32'h0000_0000 : rd_data;
        end
    end

    // ========================================================
    // bridge control register
    // a cleared strobe keeps its byte; reserved bits are masked out of every write
    always_comb begin
        bc_wmask  = BC_RW_MASK & {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
        nxt_bridge_control = (bridge_control_ff & ~bc_wmask) | (PWDATA[15:0] & bc_wmask);
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            bridge_control_ff <= BC_RESET;
        end else if (wr_en && (PADDR == ADDR_BRIDGE_CTRL)) begin
            bridge_control_ff <= nxt_bridge_control;
        end
    end

    // ========================================================
    // lock register: lockable capability fields change only while unlocked
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            unlock_ff <= UNLOCK_RESET;
        end else if (wr_en && (PADDR == ADDR_CFG_LOCK) && PSTRB[0]) begin
            unlock_ff <= PWDATA[0];
        end
    end

    // ========================================================
    // express capability header
    // fixed fields are rebuilt on every write, so no mask slip can corrupt them
    always_comb begin
        cap_wmask = CAP_RWL_MASK
                    & {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
        nxt_cap   = (cap_ff & ~cap_wmask) | (PWDATA & cap_wmask);
        nxt_cap.capability_identifier = CAP_ID;
        nxt_cap.port_type = port_up_ff ? TYPE_UPSTREAM : TYPE_DOWNSTREAM;
        nxt_cap.msi_vector_number     = MSI_NUM;
        nxt_cap.rsv31                 = 1'b0;
    end

    // straps are caught by the synchronous reset, so the port type and
    // the mode-dependent defaults stay fixed until the next reset
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            port_up_ff <= UPSTREAM_PORT;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            cap_ff.rsv31                         <= 1'b0;
            cap_ff.traffic_class_routing_support <= PCIE11_MODE ? TCS_RESET_11
                                                                : TCS_RESET;
            cap_ff.msi_vector_number             <= MSI_NUM;
            cap_ff.slot_present                  <= 1'b0;
            cap_ff.port_type                     <= UPSTREAM_PORT ? TYPE_UPSTREAM
                                                                  : TYPE_DOWNSTREAM;
            cap_ff.capability_version            <= PCIE11_MODE ? VER_RESET_11
                                                                : VER_RESET;
            cap_ff.next_capability_pointer       <= NXT_PTR_RESET;
            cap_ff.capability_identifier         <= CAP_ID;
        end else if (wr_en && (PADDR == ADDR_EXP_CAP) && unlock_ff) begin
            cap_ff <= nxt_cap;
        end
    end
    // slot-present is trusted to software; nothing here keeps it zero on an upstream port

    // ========================================================
    // secondary error handling
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            poison_ff <= 1'b0;
        end else begin
            poison_ff <= SEC_POISON_SEEN && bridge_control_ff.poison_response_enable;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            err_valid_ff <= 1'b0;
        end else begin
            err_valid_ff <= SEC_ERR_VALID && bridge_control_ff.error_forward_enable
                            && (CMD_ERR_REPORT_EN || DEVCTL_ERR_REPORT_EN);
        end
    end

    // the type follows every secondary message, forwarded or not
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            err_type_ff <= 2'h0;
        end else if (SEC_ERR_VALID) begin
            err_type_ff <= SEC_ERR_TYPE;
        end
    end

    // ========================================================
    // primary address decode
    always_comb begin
        // isa space: below 64 KB and in the top 768 bytes of a 1 KB block
        isa_upstream = bridge_control_ff.isa_routing_enable
                       && (PRI_REQ.addr[31:16] == 16'h0000)
                       && (PRI_REQ.addr[9:8] != 2'h0);
        vga_io_match = ((PRI_REQ.addr[9:0] >= VGA_IO1_LO)
                        && (PRI_REQ.addr[9:0] <= VGA_IO1_HI))
                       || ((PRI_REQ.addr[9:0] >= VGA_IO2_LO)
                        && (PRI_REQ.addr[9:0] <= VGA_IO2_HI));
        // narrow decode ignores a[15:10] so every alias matches
        if (bridge_control_ff.vga_wide_decode) begin
            vga_io_match = vga_io_match && (PRI_REQ.addr[31:10] == 22'h000000);
        end else begin
            vga_io_match = vga_io_match && (PRI_REQ.addr[31:16] == 16'h0000);
        end
        if (PRI_REQ.is_io) begin
            vga_hit = vga_io_match;
        end else begin
            vga_hit = (PRI_REQ.addr >= VGA_MEM_LO) && (PRI_REQ.addr <= VGA_MEM_HI);
        end
        vga_hit = vga_hit && bridge_control_ff.vga_forward_enable;
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            dec_valid_ff <= 1'b0;
        end else begin
            dec_valid_ff <= PRI_REQ.valid;
        end
    end

    // a request that is neither inside the window nor a vga hit stays upstream
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            dec_down_ff <= 1'b0;
        end else begin
            dec_down_ff  <= PRI_REQ.valid
                            && ((PRI_REQ.is_io && PRI_REQ.in_io_window
                                 && !isa_upstream)
                                || vga_hit);
        end
    end

    // ========================================================
    // secondary bus reset: level held while the bit stays set
    // software clears the bit to end the reset; nothing here times it out
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            rst_up_ff   <= 1'b0;
        end else begin
            rst_up_ff   <= bridge_control_ff.secondary_reset_trigger && port_up_ff;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            rst_link_ff <= 1'b0;
        end else begin
            rst_link_ff <= bridge_control_ff.secondary_reset_trigger && !port_up_ff;
        end
    end

    // ========================================================
    // outputs
    assign PRDATA             = prdata_ff;
    assign PREADY             = pready_ff;
    assign PSLVERR            = pslverr_ff;
    assign POISON_REPORT      = poison_ff;
    assign PRI_ERR_VALID      = err_valid_ff;
    assign PRI_ERR_TYPE       = err_type_ff;
    assign DEC_VALID          = dec_valid_ff;
    assign DEC_TO_SECONDARY   = dec_down_ff;
    assign SEC_RESET_UPSTREAM = rst_up_ff;
    assign SEC_RESET_LINK     = rst_link_ff;

endmodule

// file: design/bcr_pkg.sv
// package for the bridge control and express capability header block
// assumes one core clock, synchronous reset and an APB configuration port
package bcr_pkg;

    // ========================================================
    // register map: printed offsets are indices, byte address = 4 * index
    localparam logic [11:0] IDX_BRIDGE_CTRL = 12'h03e;
    localparam logic [11:0] IDX_EXP_CAP     = 12'h040;
    localparam logic [11:0] IDX_CFG_LOCK    = 12'h050;
    localparam logic [11:0] ADDR_BRIDGE_CTRL = 12'(IDX_BRIDGE_CTRL * 4);
    localparam logic [11:0] ADDR_EXP_CAP     = 12'(IDX_EXP_CAP * 4);
    localparam logic [11:0] ADDR_CFG_LOCK    = 12'(IDX_CFG_LOCK * 4);

    // ========================================================
    // bridge control
    localparam logic [15:0] BC_RESET   = 16'h0000;
    localparam logic [15:0] BC_RW_MASK = 16'h005f;

    typedef struct packed {
        logic [8:0] rsv_hi;
        logic       secondary_reset_trigger;
        logic       rsv5;
        logic       vga_wide_decode;
        logic       vga_forward_enable;
        logic       isa_routing_enable;
        logic       error_forward_enable;
        logic       poison_response_enable;
    } bcr_bridge_control_t;

    // ========================================================
    // express capability header
    localparam logic [7:0]  CAP_ID          = 8'h10;
    localparam logic [7:0]  NXT_PTR_RESET   = 8'hc0;
    localparam logic [3:0]  VER_RESET       = 4'h2;
    localparam logic [3:0]  VER_RESET_11    = 4'h1;
    localparam logic [3:0]  TYPE_UPSTREAM   = 4'h5;
    localparam logic [3:0]  TYPE_DOWNSTREAM = 4'h6;
    localparam logic [4:0]  MSI_NUM         = 5'h00;
    localparam logic        TCS_RESET       = 1'b1;
    localparam logic        TCS_RESET_11    = 1'b0;
    localparam logic [31:0] CAP_RWL_MASK    = 32'h410f_ff00;
    localparam logic        UNLOCK_RESET    = 1'b0;

    typedef struct packed {
        logic       rsv31;
        logic       traffic_class_routing_support;
        logic [4:0] msi_vector_number;
        logic       slot_present;
        logic [3:0] port_type;
        logic [3:0] capability_version;
        logic [7:0] next_capability_pointer;
        logic [7:0] capability_identifier;
    } bcr_cap_t;

    // ========================================================
    // address decode constants
    localparam logic [31:0] VGA_MEM_LO = 32'h000a_0000;
    localparam logic [31:0] VGA_MEM_HI = 32'h000b_ffff;
    localparam logic [9:0]  VGA_IO1_LO = 10'h3b0;
    localparam logic [9:0]  VGA_IO1_HI = 10'h3bb;
    localparam logic [9:0]  VGA_IO2_LO = 10'h3c0;
    localparam logic [9:0]  VGA_IO2_HI = 10'h3df;

    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic        in_io_window;
        logic [31:0] addr;
    } bcr_req_t;

endpackage

// file: verif/bcr_bridge_ctrl_chk.sv
// concurrent checks on the ports of the bridge control block
// assumes one clock, sync reset and an apb master that keeps the protocol
`timescale 1ns/1ps
module bcr_bridge_ctrl_chk
    import bcr_pkg::*;
(
    input wire logic        CLOCK,                // clock
    input wire logic        SYS_RST,              // reset
    input wire logic        PSEL,                 // select
    input wire logic        PENABLE,              // access
    input wire logic        PWRITE,               // write
    input wire logic [11:0] PADDR,                // address
    input wire logic [31:0] PWDATA,               // write data
    input wire logic [31:0] PRDATA,               // read data
    input wire logic        PREADY,               // ready
    input wire logic        PSLVERR,              // error
    input wire logic        UPSTREAM_PORT,        // strap
    input wire logic        CMD_ERR_REPORT_EN,    // enable
    input wire logic        DEVCTL_ERR_REPORT_EN, // enable
    input wire logic        SEC_POISON_SEEN,      // poison in
    input wire logic        POISON_REPORT,        // poison out
    input wire logic        SEC_ERR_VALID,        // error in
    input wire logic [1:0]  SEC_ERR_TYPE,         // type in
    input wire logic        PRI_ERR_VALID,        // error out
    input wire logic [1:0]  PRI_ERR_TYPE,         // type out
    input bcr_req_t         PRI_REQ,              // request
    input wire logic        DEC_VALID,            // decode valid
    input wire logic        DEC_TO_SECONDARY,     // decode result
    input wire logic        SEC_RESET_UPSTREAM,   // reset out
    input wire logic        SEC_RESET_LINK        // reset out
);
    // ====================================================
    // helpers
    wire req_v   = PRI_REQ.valid;
    wire err_ok  = SEC_ERR_VALID && (CMD_ERR_REPORT_EN || DEVCTL_ERR_REPORT_EN);
    wire rst_any = SEC_RESET_UPSTREAM || SEC_RESET_LINK;
    wire bc_wr6  = PSEL && PENABLE && PWRITE && PREADY && PADDR == ADDR_BRIDGE_CTRL && PWDATA[6];
    // io outside the window may only pass as a vga address below 64k
    wire fwd_ok  = PRI_REQ.is_io ? (PRI_REQ.in_io_window || PRI_REQ.addr[31:16] == 16'h0000)
                                 : PRI_REQ.addr[31:17] == 15'h0005;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        PENABLE && !PREADY ##1 PENABLE && PREADY;
    endsequence
    // ====================================================
    // assertions
    chk_apb_wait: assert property (s_setup |=> s_access)
        else $error("apb answer timing wrong");
    chk_poison_cause: assert property (POISON_REPORT |-> $past(SEC_POISON_SEEN))
        else $error("poison report without cause");
    chk_err_cause: assert property (PRI_ERR_VALID |-> $past(err_ok))
        else $error("error forwarded without cause");
    chk_err_type: assert property (SEC_ERR_VALID |=>
        PRI_ERR_TYPE == $past(SEC_ERR_TYPE)) else $error("error type not carried");
    chk_dec_follow: assert property (DEC_VALID == ($past(req_v) && !$past(SYS_RST)))
        else $error("decode valid not one cycle late");
    chk_fwd_cause: assert property (DEC_TO_SECONDARY |-> DEC_VALID && $past(fwd_ok))
        else $error("forward outside window or vga");
    chk_rst_side: assert property (!(SEC_RESET_UPSTREAM && !UPSTREAM_PORT)
        && !(SEC_RESET_LINK && UPSTREAM_PORT)) else $error("secondary reset on wrong side");
    chk_rst_write: assert property ($rose(rst_any) |-> $past(bc_wr6, 2))
        else $error("secondary reset without write");
    chk_cap_fixed: assert property (PREADY && !PWRITE
        && PADDR == ADDR_EXP_CAP |->
        PRDATA[7:0] == 8'h10 && PRDATA[31] == 1'b0 && PRDATA[29:25] == 5'h00
        && PRDATA[23:20] == (UPSTREAM_PORT ? 4'h5 : 4'h6)) else $error("fixed cap field wrong");
    chk_bc_rsv: assert property (PREADY && !PWRITE && PADDR == ADDR_BRIDGE_CTRL |->
        PRDATA[31:7] == 25'h0 && !PRDATA[5]) else $error("reserved control bit set");
endmodule

bind bcr_bridge_ctrl bcr_bridge_ctrl_chk i_bcr_bridge_ctrl_chk (.*);

// file: verif/bcr_bridge_ctrl_tb.sv
// self-checking bench for the bridge control and capability header block
// assumes the design package, the checker bind and the traffic model
`timescale 1ns/1ps
module bcr_bridge_ctrl_tb_top
    import bcr_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        up = 1'b0, m11 = 1'b0, en = 1'b0, armed = 1'b0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q, w, cap_m;
    logic [15:0] bc_m = 16'h0000;
    logic        pready, pslverr, prep, pev, dv, ds, sru, srl, poison, err_v, cmd_en, dev_en;
    logic        ep, ev, edv, eds, eru, erl;
    logic [1:0]  err_t, pet, et;
    logic [3:0]  pstrb = 4'hf;
    bcr_req_t    req;
    int          failures = 0, samples_checked = 0, seed = 20;

    bcr_bridge_ctrl i_bcr_bridge_ctrl (
        .CLOCK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .UPSTREAM_PORT(up), .PCIE11_MODE(m11), .CMD_ERR_REPORT_EN(cmd_en),
        .DEVCTL_ERR_REPORT_EN(dev_en), .SEC_POISON_SEEN(poison), .POISON_REPORT(prep),
        .SEC_ERR_VALID(err_v), .SEC_ERR_TYPE(err_t), .PRI_ERR_VALID(pev), .PRI_ERR_TYPE(pet),
        .PRI_REQ(req), .DEC_VALID(dv), .DEC_TO_SECONDARY(ds), .SEC_RESET_UPSTREAM(sru),
        .SEC_RESET_LINK(srl));
    bcr_link_model i_bcr_link_model (.clk(clk), .en(en), .poison(poison), .err_v(err_v),
        .err_t(err_t), .cmd_en(cmd_en), .dev_en(dev_en), .req(req));

    initial forever #5 clk = ~clk;

    // ====================================================
    // tasks
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one idle cycle after each transfer keeps a signal from being driven twice at one edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic [15:0] bm;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        bm = 16'h005f & {{8{pstrb[1]}}, {8{pstrb[0]}}};
        if (wr && a == ADDR_BRIDGE_CTRL) bc_m = (bc_m & ~bm) | (d[15:0] & bm);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset(input logic u, input logic m);
        rst <= 1'b1;
        up <= u;
        m11 <= m;
        bc_m = 16'h0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic fwd(input bcr_req_t r, input logic [15:0] b);
        int unsigned a, lo;
        logic        vio;
        a = r.addr;
        lo = a % 1024;
        vio = (lo >= 32'h3b0 && lo <= 32'h3bb) || (lo >= 32'h3c0 && lo <= 32'h3df);
        vio = vio && a < (b[4] ? 32'h0000_0400 : 32'h0001_0000);
        if (!r.valid) return 1'b0;
        if (r.is_io && r.in_io_window && !(b[2] && a < 32'h0001_0000 && lo >= 32'h100))
            return 1'b1;
        return b[3] && (r.is_io ? vio : (a >= 32'h000a_0000 && a <= 32'h000b_ffff));
    endfunction

    // ====================================================
    // side outputs against the model, one cycle behind the inputs
    always @(negedge clk) begin
        if (armed) begin
            chk("poison", ep, prep);
            chk("err valid", ev, pev);
            chk("err type", et, pet);
            chk("dec valid", edv, dv);
            chk("dec fwd", eds, ds);
            chk("rst up", eru, sru);
            chk("rst link", erl, srl);
        end
        armed = 1'b1;
        if (rst) begin
            {ep, ev, et, edv, eds, eru, erl} = '0;
        end else begin
            ep = bc_m[0] & poison;
            ev = bc_m[1] & err_v & (cmd_en | dev_en);
            et = err_v ? err_t : et;
            edv = req.valid;
            eds = fwd(req, bc_m);
            eru = bc_m[6] & up;
            erl = bc_m[6] & !up;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done;
    end

    initial begin
        for (int i = 0; i < 4; i++) begin
            do_reset(i[0], i[1]);
            cap_m = {1'b0, !m11, 5'h00, 1'b0, up ? 4'h5 : 4'h6, m11 ? 4'h1 : 4'h2, 16'hc010};
            apb(1'b0, ADDR_EXP_CAP, 32'h0);
            chk("cap", cap_m, q);
            chk("cap err", 32'h0, e);
            apb(1'b0, ADDR_BRIDGE_CTRL, 32'h0);
            chk("bridge_control reset", 32'h0, q);
            apb(1'b1, ADDR_EXP_CAP, 32'hffff_ffff);
            apb(1'b0, ADDR_EXP_CAP, 32'h0);
            chk("cap locked", cap_m, q);
            apb(1'b1, ADDR_CFG_LOCK, 32'h1);
            apb(1'b0, ADDR_CFG_LOCK, 32'h0);
            chk("unlock", 32'h1, q);
            w = $random(seed);
            w[24] = w[24] & !up;
            apb(1'b1, ADDR_EXP_CAP, w);
            cap_m = (cap_m & ~CAP_RWL_MASK) | (w & CAP_RWL_MASK);
            apb(1'b0, ADDR_EXP_CAP, 32'h0);
            chk("cap open", cap_m, q);
            apb(1'b1, 12'h0fc, w);
            chk("unmapped wr err", 1'b1, e);
            apb(1'b0, 12'h0fc, 32'h0);
            chk("unmapped rd", 32'h0, q);
            en <= 1'b1;
            for (int j = 0; j < 6; j++) begin
                w = j == 0 ? '1 : j == 1 ? 32'h0000_0008 : $random(seed);
                pstrb <= j < 2 ? 4'hf : 4'($random(seed));
                apb(1'b1, ADDR_BRIDGE_CTRL, w);
                apb(1'b0, ADDR_BRIDGE_CTRL, 32'h0);
                chk("bridge_control", {16'h0000, bc_m}, q);
                repeat (150) @(posedge clk);
            end
            en <= 1'b0;
            pstrb <= 4'hf;
            $display("test with straps %0d done", i);
        end
        test_done;
    end
endmodule

// file: verif/bcr_link_model.sv
// random traffic of the primary and secondary interfaces
// assumes it is sampled on the rising edge of the core clock
`timescale 1ns/1ps
module bcr_link_model
    import bcr_pkg::*;
(
    input  wire logic       clk,    // core clock
    input  wire logic       en,     // traffic on
    output logic            poison, // poisoned packet
    output logic            err_v,  // error message
    output logic      [1:0] err_t,  // error type
    output logic            cmd_en, // command enable
    output logic            dev_en, // devctl enable
    output bcr_req_t        req     // primary request
);
    int          seed = 20;
    logic [31:0] r;
    logic [31:0] a;
    initial {poison, err_v, err_t, cmd_en, dev_en, req} = '0;
    // ====================================================
    // masks steer addresses towards the vga and isa ranges
    always @(posedge clk) begin
        r = $random(seed);
        a = $random(seed);
        a = a & (r[7] ? 32'h0000_03ff : r[8] ? 32'h0000_ffff : r[9] ? 32'h000b_ffff : '1);
        poison <= en & r[0];
        err_v  <= en & r[1];
        err_t  <= 2'(r[3:2] % 3);
        cmd_en <= r[4];
        dev_en <= r[5];
        req    <= '{valid: en & r[6], is_io: r[10], in_io_window: r[11], addr: a};
    end
endmodule
